// ==== hw/i2cra_top.sv ====
// two-wire target engine: address match, pointer, burst write and read, high-speed entry
// assumes a register file on the core clock that answers rd_data_i combinationally
`timescale 1ns/1ns
`default_nettype none
module i2cra_top (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [1:0] addr_sel_i,
	output logic hs_mode_o,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic [7:0] rd_addr_o,
	input wire logic [7:0] rd_data_i,
	output logic rd_take_o
);
	i2cra_line_if ln ();

	i2cra_line_sync u_sync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.ln(ln)
	);

	i2cra_pkg::i2cra_state_e state_q, state_d;
	i2cra_pkg::i2cra_state_e nxt_q, nxt_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shreg_q, shreg_d;
	logic [7:0] ptr_q, ptr_d;
	logic drive_q, drive_d;
	logic ackph_q, ackph_d;
	logic ack_en_q, ack_en_d;
	logic mack_q, mack_d;
	logic hs_q, hs_d;
	logic pend_v_q, pend_v_d;
	logic [7:0] pend_a_q, pend_a_d;
	logic [7:0] pend_b_q, pend_b_d;
	logic arm_q, arm_d;
	logic push_q, push_d;
	logic [15:0] push_w_q, push_w_d;
	logic take_q, take_d;
	logic [1:0] sel_m_q, sel_q;
	logic [7:0] byte_in;
	logic buf_in_ready;
	logic [15:0] buf_out;

	// option strap passes two flops before use
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sel_m_q <= 2'h0;
			sel_q <= 2'h0;
		end else begin
			sel_m_q <= addr_sel_i;
			sel_q <= sel_m_q;
		end
	end

	assign byte_in = {shreg_q[6:0], ln.sda_lvl};

	always_comb begin
		state_d = state_q;
		nxt_d = nxt_q;
		cnt_d = cnt_q;
		shreg_d = shreg_q;
		ptr_d = ptr_q;
		drive_d = drive_q;
		ackph_d = ackph_q;
		ack_en_d = ack_en_q;
		mack_d = mack_q;
		hs_d = hs_q;
		pend_v_d = pend_v_q;
		pend_a_d = pend_a_q;
		pend_b_d = pend_b_q;
		arm_d = arm_q;
		push_d = push_q & ~buf_in_ready;
		push_w_d = push_w_q;
		take_d = 1'b0;
		// pending write lands on the next rising data line after its ack slot
		if (arm_q && pend_v_q && ln.sda_rise) begin
			push_d = 1'b1;
			push_w_d = {pend_a_q, pend_b_q};
			pend_v_d = 1'b0;
			arm_d = 1'b0;
		end
		if (ln.stop) begin
			state_d = i2cra_pkg::st_idle;
			cnt_d = 4'h0;
			drive_d = 1'b0;
			ackph_d = 1'b0;
			hs_d = 1'b0;
		end else if (ln.start) begin
			state_d = i2cra_pkg::st_addr;
			cnt_d = 4'h0;
			drive_d = 1'b0;
			ackph_d = 1'b0;
		end else begin
			unique case (state_q)
				i2cra_pkg::st_idle: begin
					drive_d = 1'b0;
				end
				i2cra_pkg::st_ignore: begin
					drive_d = 1'b0;
				end
				i2cra_pkg::st_addr: begin
					if (ln.scl_rise) begin
						shreg_d = byte_in;
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == i2cra_pkg::BITS_PER_BYTE - 4'h1) begin
							state_d = i2cra_pkg::st_ack;
							ackph_d = 1'b0;
							if (byte_in[7:3] == i2cra_pkg::HS_CODE_TOP) begin
								ack_en_d = 1'b0;
								hs_d = 1'b1;
								nxt_d = i2cra_pkg::st_ignore;
							end else if (byte_in[7:1] == i2cra_pkg::i2cra_target(sel_q)
								&& byte_in[7:1] != i2cra_pkg::GEN_CALL_ADDR) begin
								ack_en_d = 1'b1;
								nxt_d = byte_in[0] ? i2cra_pkg::st_tx : i2cra_pkg::st_ptr;
							end else begin
								ack_en_d = 1'b0;
								nxt_d = i2cra_pkg::st_ignore;
							end
						end
					end
				end
				i2cra_pkg::st_ptr: begin
					if (ln.scl_rise) begin
						shreg_d = byte_in;
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == i2cra_pkg::BITS_PER_BYTE - 4'h1) begin
							ptr_d = byte_in;
							ack_en_d = 1'b1;
							ackph_d = 1'b0;
							nxt_d = i2cra_pkg::st_wdata;
							state_d = i2cra_pkg::st_ack;
						end
					end
				end
				i2cra_pkg::st_wdata: begin
					if (ln.scl_rise) begin
						shreg_d = byte_in;
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == i2cra_pkg::BITS_PER_BYTE - 4'h1) begin
							if (pend_v_q) begin
								push_d = 1'b1;
								push_w_d = {pend_a_q, pend_b_q};
							end
							pend_v_d = 1'b1;
							pend_a_d = ptr_q;
							pend_b_d = byte_in;
							arm_d = 1'b0;
							ptr_d = ptr_q + 8'h01;
							ack_en_d = 1'b1;
							ackph_d = 1'b0;
							nxt_d = i2cra_pkg::st_wdata;
							state_d = i2cra_pkg::st_ack;
						end
					end
				end
				i2cra_pkg::st_ack: begin
					if (ln.scl_rise) begin
						ackph_d = 1'b1;
					end else if (ln.scl_fall && !ackph_q) begin
						drive_d = ack_en_q;
					end else if (ln.scl_fall && ackph_q) begin
						ackph_d = 1'b0;
						cnt_d = 4'h0;
						drive_d = 1'b0;
						state_d = nxt_q;
						arm_d = pend_v_q;
						if (nxt_q == i2cra_pkg::st_tx) begin
							shreg_d = rd_data_i;
							drive_d = ~rd_data_i[7];
							take_d = 1'b1;
						end
					end
				end
				i2cra_pkg::st_tx: begin
					if (ln.scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (ln.scl_fall) begin
						if (cnt_q == i2cra_pkg::BITS_PER_BYTE) begin
							drive_d = 1'b0;
							ackph_d = 1'b0;
							state_d = i2cra_pkg::st_mack;
						end else begin
							shreg_d = {shreg_q[6:0], 1'b0};
							drive_d = ~shreg_q[6];
						end
					end
				end
				i2cra_pkg::st_mack: begin
					if (ln.scl_rise) begin
						ackph_d = 1'b1;
						mack_d = ~ln.sda_lvl;
						if (!ln.sda_lvl) begin
							ptr_d = ptr_q + 8'h01;
						end
					end else if (ln.scl_fall && ackph_q) begin
						ackph_d = 1'b0;
						cnt_d = 4'h0;
						if (mack_q) begin
							state_d = i2cra_pkg::st_tx;
							shreg_d = rd_data_i;
							drive_d = ~rd_data_i[7];
							take_d = 1'b1;
						end else begin
							state_d = i2cra_pkg::st_ignore;
							drive_d = 1'b0;
						end
					end
				end
				default: begin
					state_d = i2cra_pkg::st_idle;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_q <= i2cra_pkg::st_idle;
			nxt_q <= i2cra_pkg::st_idle;
			cnt_q <= 4'h0;
			shreg_q <= 8'h00;
			ptr_q <= i2cra_pkg::PTR_RESET;
			drive_q <= 1'b0;
			ackph_q <= 1'b0;
			ack_en_q <= 1'b0;
			mack_q <= 1'b0;
			hs_q <= 1'b0;
			pend_v_q <= 1'b0;
			pend_a_q <= 8'h00;
			pend_b_q <= 8'h00;
			arm_q <= 1'b0;
			push_q <= 1'b0;
			push_w_q <= 16'h0000;
			take_q <= 1'b0;
		end else begin
			state_q <= state_d;
			nxt_q <= nxt_d;
			cnt_q <= cnt_d;
			shreg_q <= shreg_d;
			ptr_q <= ptr_d;
			drive_q <= drive_d;
			ackph_q <= ackph_d;
			ack_en_q <= ack_en_d;
			mack_q <= mack_d;
			hs_q <= hs_d;
			pend_v_q <= pend_v_d;
			pend_a_q <= pend_a_d;
			pend_b_q <= pend_b_d;
			arm_q <= arm_d;
			push_q <= push_d;
			push_w_q <= push_w_d;
			take_q <= take_d;
		end
	end

	i2cra_pair_fifo #(
		.WIDTH(16),
		.DEPTH(i2cra_pkg::BUF_DEPTH)
	) u_buf (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.in_valid_i(push_q),
		.in_ready_o(buf_in_ready),
		.in_data_i(push_w_q),
		.out_valid_o(wr_valid_o),
		.out_ready_i(wr_ready_i),
		.out_data_o(buf_out)
	);

	assign wr_addr_o = buf_out[15:8];
	assign wr_data_o = buf_out[7:0];
	assign rd_addr_o = ptr_q;
	assign rd_take_o = take_q;
	assign hs_mode_o = hs_q;
	// open drain: only ever pulls low; no clock output exists
	assign sda_o = 1'b0;
	assign sda_oe_o = drive_q;
endmodule
`default_nettype wire

// ==== hw/i2cra_pkg.sv ====
// constants, state enum and address decode for the serial register access target
// assumes a single core clock; bus lines arrive asynchronously
// Summary of operation
// - start, address with write bit, matching address acked
// - pointer byte acknowledged and stored as address
// - written byte commits on next data-line rise
// - single write data byte is always answered with ack
// - burst write bytes go to successive addresses
// - stop restores slow filters, repeated start keeps them
// - eight bits of pointed register, msb first
// - master ack requests next sequential register
// - stop leaves register pointer unchanged
// - high-speed code gets nack, filters go fast
// - repeated starts keep high-speed, stop ends it
// - every pointer value in 8-bit space acked
// - one of four optioned target addresses answered
// - clock line is never held low
// - general call address is never acknowledged
package i2cra_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [6:0] TGT_ADDR_0 = 7'h40;
	localparam logic [6:0] TGT_ADDR_1 = 7'h44;
	localparam logic [6:0] TGT_ADDR_2 = 7'h48;
	localparam logic [6:0] TGT_ADDR_3 = 7'h52;
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic [4:0] HS_CODE_TOP = 5'h01;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_ptr,
		st_wdata,
		st_ack,
		st_tx,
		st_mack,
		st_ignore
	} i2cra_state_e;

	function automatic logic [6:0] i2cra_target(input logic [1:0] sel);
		logic [6:0] a;
		a = TGT_ADDR_0;
		unique case (sel)
			2'h0: a = TGT_ADDR_0;
			2'h1: a = TGT_ADDR_1;
			2'h2: a = TGT_ADDR_2;
			2'h3: a = TGT_ADDR_3;
		endcase
		return a;
	endfunction
endpackage

// ==== hw/i2cra_line_if.sv ====
// conditioned bus-line events passed from the line sampler to the engine
// assumes all events except the sda_lvl level are one-cycle pulses on the core clock
`timescale 1ns/1ns
`default_nettype none
interface i2cra_line_if;
	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_lvl;
	logic start;
	logic stop;
	modport src (output scl_rise, output scl_fall, output sda_rise, output sda_lvl,
		output start, output stop);
	modport snk (input scl_rise, input scl_fall, input sda_rise, input sda_lvl,
		input start, input stop);
endinterface
`default_nettype wire

// ==== hw/i2cra_line_sync.sv ====
// two-flop synchronisers for clock and data lines, edge and condition detect
// assumes the core clock is many times faster than the bus clock
`timescale 1ns/1ns
`default_nettype none
module i2cra_line_sync (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic sda_i,
	i2cra_line_if.src ln
);
	logic [1:0] scl_m_q, scl_m_d;
	logic [1:0] sda_m_q, sda_m_d;
	logic [1:0] scl_h_q, scl_h_d;
	logic [1:0] sda_h_q, sda_h_d;

	always_comb begin
		scl_m_d = {scl_m_q[0], scl_i};
		sda_m_d = {sda_m_q[0], sda_i};
		scl_h_d = {scl_h_q[0], scl_m_q[1]};
		sda_h_d = {sda_h_q[0], sda_m_q[1]};
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			scl_m_q <= 2'h3;
			sda_m_q <= 2'h3;
			scl_h_q <= 2'h3;
			sda_h_q <= 2'h3;
		end else begin
			scl_m_q <= scl_m_d;
			sda_m_q <= sda_m_d;
			scl_h_q <= scl_h_d;
			sda_h_q <= sda_h_d;
		end
	end

	// stage h[0] is current, h[1] previous sample
	assign ln.scl_rise = scl_h_q[0] & ~scl_h_q[1];
	assign ln.scl_fall = ~scl_h_q[0] & scl_h_q[1];
	assign ln.sda_rise = sda_h_q[0] & ~sda_h_q[1];
	assign ln.sda_lvl = sda_h_q[0];
	assign ln.start = scl_h_q[0] & scl_h_q[1] & ~sda_h_q[0] & sda_h_q[1];
	assign ln.stop = scl_h_q[0] & scl_h_q[1] & sda_h_q[0] & ~sda_h_q[1];
endmodule
`default_nettype wire

// ==== hw/i2cra_pair_fifo.sv ====
// small valid/ready buffer between the serial engine and the register file
// assumes both sides run on the core clock
`timescale 1ns/1ns
`default_nettype none
module i2cra_pair_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = i2cra_pkg::BUF_DEPTH
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	// pointers wrap on their own only for powers of two
	if (DEPTH != 2 && DEPTH != 4 && DEPTH != 8) begin : g_bad_depth
		$error("depth must be 2, 4 or 8");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
		cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
		if (push) mem_q[wp_q] <= in_data_i;
	end

	assign in_ready_o = (cnt_q != DEPTH[PW:0]);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rp_q];
endmodule
`default_nettype wire

// ==== test/i2cra_properties.sv ====
// port checker for the two-wire target engine
// assumes bus lines with pull-ups and a 250 MHz core clock
`timescale 1ns/1ns
`default_nettype none
module i2cra_properties (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_oe_o,
	input wire logic hs_mode_o,
	input wire logic wr_valid_o,
	input wire logic wr_ready_i,
	input wire logic [7:0] wr_addr_o,
	input wire logic [7:0] wr_data_o,
	input wire logic rd_take_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic hs_win_q;
	// open from fast-code entry until the next start on the bus
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			hs_win_q <= 1'b0;
		end else if ($rose(hs_mode_o)) begin
			hs_win_q <= 1'b1;
		end else if (scl_i && $fell(sda_i)) begin
			hs_win_q <= 1'b0;
		end
	end
	sequence s_reset_held;
		reset_i ##1 reset_i;
	endsequence
	a_rst_clears: assert property (disable iff (1'b0) s_reset_held |->
		!sda_oe_o && !hs_mode_o && !wr_valid_o) else $error("outputs not cleared by reset");
	a_word_holds: assert property (wr_valid_o && !wr_ready_i |=>
		wr_valid_o && $stable({wr_addr_o, wr_data_o})) else $error("write word moved");
	a_valid_drop: assert property ($fell(wr_valid_o) |-> $past(wr_ready_i))
		else $error("write word lost");
	a_take_pulse: assert property (rd_take_o |=> !rd_take_o) else $error("take too long");
	a_take_scl_low: assert property (rd_take_o |-> !scl_i) else $error("take off clock low");
	a_oe_scl_low: assert property (!$stable(sda_oe_o) |-> !scl_i)
		else $error("data line moved with clock high");
	a_hs_stop: assert property ($fell(hs_mode_o) |-> scl_i && sda_i)
		else $error("fast filters left without stop");
	a_hs_nack: assert property (($rose(hs_mode_o) || hs_win_q) |-> !sda_oe_o)
		else $error("fast code acked");
endmodule
`default_nettype wire

// ==== test/i2cra_bus_master.sv ====
// behavioural bus controller: start, stop, byte transfer, 160 ns bit time
// assumes a resolved data line with pull-up on sda_i
`timescale 1ns/1ns
`default_nettype none
module i2cra_bus_master (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// one bit; a 1 releases the line so the target may answer
	task automatic bit_io(input logic b, output logic r);
		sda_o <= b;
		tick(10);
		scl_o <= 1'b1;
		tick(10);
		r = sda_i;
		tick(10);
		scl_o <= 1'b0;
		tick(10);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ak, a);
	endtask
	task automatic start();
		sda_o <= 1'b1;
		tick(10);
		scl_o <= 1'b1;
		tick(10);
		sda_o <= 1'b0;
		tick(10);
		scl_o <= 1'b0;
		tick(10);
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		tick(10);
		scl_o <= 1'b1;
		tick(10);
		sda_o <= 1'b1;
		tick(20);
	endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// testbench: bus controller model, register file model, random and corner traffic
// assumes the checker is bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clock_i, reset_i, wr_ready_i, stall, sda_o, sda_oe_o, hs_mode_o, wr_valid_o, rd_take_o;
	logic scl_m, sda_m;
	logic [1:0] addr_sel_i;
	logic [7:0] wr_addr_o, wr_data_o, rd_addr_o;
	logic [7:0] mem [256];
	logic [31:0] lfsr = 32'hD3B90F1C;
	int failures = 0, checks = 0, cycles = 0;
	wire sda_w = sda_m & (~sda_oe_o | sda_o);
	wire [7:0] rd_data_w = mem[rd_addr_o];
	i2cra_top i2cra_top_i (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_m), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i), .hs_mode_o(hs_mode_o),
		.wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_w), .rd_take_o(rd_take_o));
	i2cra_bus_master i2cra_bus_master_i (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl_m),
		.sda_o(sda_m));
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [6:0] addr_of(input logic [1:0] s);
		return s == 2'h3 ? 7'h52 : 7'h40 + {3'h0, s, 2'h0};
	endfunction
	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] d, input logic nack);
		logic [7:0] q;
		logic a;
		i2cra_bus_master_i.xfer(d, 1'b1, q, a);
		check({7'h00, a}, {7'h00, nack}, "answer");
	endtask
	task automatic recv(input logic [7:0] exp, input logic mack);
		logic [7:0] q;
		logic a;
		i2cra_bus_master_i.xfer(8'hFF, mack, q, a);
		check(q, exp, "read");
	endtask
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		lfsr <= step(lfsr);
		wr_ready_i <= lfsr[3] & ~stall;
		if (wr_valid_o && wr_ready_i)
			mem[wr_addr_o] <= wr_data_o;
		if (cycles == 90000) begin
			failures++;
			results();
		end
	end
	initial begin
		logic [7:0] p, d0, d1;
		logic [6:0] ad;
		reset_i = 1'b1;
		addr_sel_i = 2'h0;
		stall = 1'b0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i * 37 + 5);
		end
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		for (int k = 0; k < 6; k++) begin
			addr_sel_i <= k < 4 ? 2'(k) : lfsr[1:0];
			ad = addr_of(k < 4 ? 2'(k) : lfsr[1:0]);
			p = k == 0 ? 8'hFF : lfsr[15:8];
			d0 = lfsr[23:16];
			d1 = lfsr[31:24];
			stall <= k == 1;
			repeat (4) @(posedge clock_i);
			i2cra_bus_master_i.start();
			send({ad, 1'b0}, 1'b0);
			send(p, 1'b0);
			send(d0, 1'b0);
			send(d1, 1'b0);
			i2cra_bus_master_i.stop();
			repeat (20) @(posedge clock_i);
			check({7'h00, wr_valid_o}, {7'h00, k == 1}, "held");
			stall <= 1'b0;
			repeat (30) @(posedge clock_i);
			check(mem[p], d0, "first");
			check(mem[8'(p + 1)], d1, "second");
			check({7'h00, wr_valid_o}, 8'h00, "drained");
			i2cra_bus_master_i.start();
			send({ad, 1'b0}, 1'b0);
			send(p, 1'b0);
			i2cra_bus_master_i.start();
			send({ad, 1'b1}, 1'b0);
			recv(d0, 1'b0);
			recv(d1, 1'b1);
			check({7'h00, sda_oe_o}, 8'h00, "released");
			i2cra_bus_master_i.stop();
			i2cra_bus_master_i.start();
			send({ad, 1'b1}, 1'b0);
			recv(d1, 1'b1);
			i2cra_bus_master_i.stop();
			i2cra_bus_master_i.start();
			send({ad ^ 7'h01, 1'b0}, 1'b1);
			send(8'h00, 1'b1);
			i2cra_bus_master_i.start();
			send(8'h00, 1'b1);
			i2cra_bus_master_i.stop();
		end
		for (int j = 8; j < 16; j += 7) begin
			i2cra_bus_master_i.start();
			send(8'(j), 1'b1);
			check({7'h00, hs_mode_o}, 8'h01, "fast on");
			i2cra_bus_master_i.start();
			send({ad, 1'b1}, 1'b0);
			recv(d1, 1'b1);
			check({7'h00, hs_mode_o}, 8'h01, "fast kept");
			i2cra_bus_master_i.stop();
			check({7'h00, hs_mode_o}, 8'h00, "fast off");
		end
		results();
	end
endmodule
bind i2cra_top i2cra_properties i2cra_properties_i (.clock_i, .reset_i, .scl_i, .sda_i,
	.sda_oe_o, .hs_mode_o, .wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_data_o, .rd_take_o);
`default_nettype wire
